// ==== pkg/spps_defs.vh ====
// offsets, field positions, reset values and command codes of the sdram core
`ifndef SPPS_DEFS_VH
`define SPPS_DEFS_VH

`define SPPS_MODE_ADDR   8'h00
`define SPPS_STATUS_ADDR 8'h04

`define SPPS_MODE_W      5
`define SPPS_MODE_RST    5'h00
`define SPPS_MODE_CL3    0
`define SPPS_MODE_BL_LSB 1
`define SPPS_MODE_BL_MSB 2
`define SPPS_MODE_WBM    3
`define SPPS_MODE_WR2    4

`define SPPS_CMD_ACT     3'h3
`define SPPS_CMD_RD      3'h5
`define SPPS_CMD_WR      3'h4
`define SPPS_CMD_PRE     3'h2
`define SPPS_CMD_REF     3'h1
`define SPPS_CMD_BST     3'h6
`define SPPS_CMD_NOP     3'h7

`define SPPS_TWR_ONE     2'h1
`define SPPS_TWR_TWO     2'h2
`define SPPS_INIT_REFS   2'h2

`endif

// ==== hw/spps_core.v ====
// sdram command core: precharge, power-down, clock suspend, apb mode regs
`timescale 1ns/100ps
`default_nettype none
`include "spps_defs.vh"
// Operation
// (RULE1) precharge closes one bank or all, chosen by the all-banks bit
// (RULE2) all-banks precharge ignores both bank-select inputs
// (RULE3) controller waits precharge time and activates before read or write
// (RULE4) cke low with nop and no access enters power-down
// (RULE5) idle banks mean precharge power-down, open rows mean active one
// (RULE6) power-down ignores all inputs but cke and does no refresh; code also needs a nop or deselect command to leave
// (RULE7) controller leaves power-down before the refresh period runs out
// (RULE8) cke high with nop leaves power-down on that edge
// (RULE9) cke low during a burst suspends the clock instead of powering down
// (RULE10) each edge with cke low skips the next internal edge
// (RULE11) suspended edges ignore inputs, keep outputs, freeze burst counters; code clears mem_wr_en on them
// (RULE12) cke high resumes internal clocking on the next edge
// (RULE13) write burst mode bit set makes every write a single column
// (RULE14) reads and normal writes follow the programmed burst length
// (RULE15) access to another bank during auto precharge access is accepted
// (RULE16) read cuts auto precharge read; old bank precharge starts at once
// (RULE17) write ends auto precharge read; old bank precharge starts at once
// (RULE18) controller raises byte mask two clocks before a write after read
// (RULE19) read ends auto precharge write; precharge after write recovery
// (RULE20) write ends auto precharge write; precharge after write recovery
// (RULE21) write recovery is one clock, or two when period is short
// (RULE22) controller pauses after power-up then gives two auto refreshes
// (RULE23) byte mask delays read output two clocks, write input zero
// (RULE24) per-bank idle or active state picks power-down kind, gates access
module spps_core (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        cke,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [10:0] addr,
   input  wire        bank_select_low,
   input  wire        bank_select_high,
   input  wire        dqm,
   input  wire [31:0] dq_in,
   output reg  [31:0] dq_out,
   output reg         dq_oe,
   input  wire [31:0] mem_rdata,
   output reg         mem_wr_en,
   output reg         mem_rd_en,
   output reg  [1:0]  mem_bank,
   output reg  [10:0] mem_row,
   output reg  [7:0]  mem_col,
   output reg  [31:0] mem_wdata
);

   localparam [1:0] PS_RUN    = 2'h0;
   localparam [1:0] PS_PRE_PD = 2'h1;
   localparam [1:0] PS_ACT_PD = 2'h2;
   localparam [1:0] PS_SUSP   = 2'h3;

   function [8:0] burst_len;
      input [1:0] code;
      begin
         case (code)
            2'h0:    burst_len = 9'h001;
            2'h1:    burst_len = 9'h002;
            2'h2:    burst_len = 9'h004;
            default: burst_len = 9'h008;
         endcase
      end
   endfunction

   function is_nop;
      input       cs;
      input [2:0] code;
      begin
         is_nop = cs | (code == `SPPS_CMD_NOP);
      end
   endfunction

   reg [`SPPS_MODE_W-1:0] mode;
   reg [1:0]              pwr_state;
   reg                    cke_prev;
   reg                    burst_active;
   reg                    burst_rd;
   reg                    burst_ap;
   reg [1:0]              burst_bank;
   reg [7:0]              burst_col;
   reg [8:0]              burst_left;
   reg [1:0]              ref_cnt;
   reg                    rd_v0;
   reg                    rd_v1;
   reg [31:0]             rd_d0;
   reg [31:0]             rd_d1;
   reg                    dqm_d0;
   reg                    dqm_d1;

   wire [3:0]  bank_open;
   wire [3:0]  rec_busy;
   wire [43:0] rows;

   wire [2:0] code     = {ras_n, cas_n, we_n};
   wire [1:0] cmd_bank = {bank_select_high, bank_select_low};
   wire       cmd_act  = ~cs_n & (code == `SPPS_CMD_ACT);
   wire       cmd_rd   = ~cs_n & (code == `SPPS_CMD_RD);
   wire       cmd_wr   = ~cs_n & (code == `SPPS_CMD_WR);
   wire       cmd_pre  = ~cs_n & (code == `SPPS_CMD_PRE);
   wire       cmd_ref  = ~cs_n & (code == `SPPS_CMD_REF);
   wire       cmd_bst  = ~cs_n & (code == `SPPS_CMD_BST);

   // internal edge is live only when cke was high one edge earlier
   wire run_edge = (pwr_state == PS_RUN) & cke_prev; // RULE10

   // accesses to a closed bank are dropped
   wire new_acc = run_edge & (cmd_rd | cmd_wr) & bank_open[cmd_bank]; // RULE24
   wire stop    = cmd_bst | (cmd_pre & (addr[10] | cmd_bank == burst_bank));
   wire acc_go  = new_acc | (run_edge & burst_active & ~stop);
   wire acc_rd  = new_acc ? cmd_rd : burst_rd;
   wire acc_ap  = new_acc ? addr[10] : burst_ap;
   wire [1:0] acc_bank = new_acc ? cmd_bank : burst_bank;
   wire [7:0] acc_col  = new_acc ? addr[7:0] : burst_col;
   wire [8:0] wr_len   = mode[`SPPS_MODE_WBM] ? 9'h001 : // RULE13
                         burst_len(mode[`SPPS_MODE_BL_MSB:`SPPS_MODE_BL_LSB]);
   wire [8:0] rd_len   = burst_len(mode[`SPPS_MODE_BL_MSB:`SPPS_MODE_BL_LSB]);
   wire [8:0] acc_left = new_acc ? (cmd_rd ? rd_len : wr_len) : // RULE14
                         burst_left;
   wire       acc_last = (acc_left == 9'h001);
   wire [1:0] twr      = mode[`SPPS_MODE_WR2] ? `SPPS_TWR_TWO : // RULE21
                         `SPPS_TWR_ONE;

   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1) begin : g_bank
         reg        open_r;
         reg [10:0] row_r;
         reg [1:0]  rec_r;
         wire old_hit = burst_active & burst_ap & (burst_bank == b);
         // another bank's access while this one auto-precharges
         wire intr    = new_acc & old_hit & (cmd_bank != b); // RULE15
         wire end_hit = acc_go & acc_last & acc_ap & (acc_bank == b);
         wire rd_cls  = (intr & burst_rd) | (end_hit & acc_rd); // RULE16 RULE17
         wire rec_go  = (intr & ~burst_rd) | (end_hit & ~acc_rd); // RULE19 RULE20
         wire pre_cls = run_edge & cmd_pre &
                        (addr[10] | (cmd_bank == b)); // RULE1 RULE2
         wire rec_cls = run_edge & (rec_r == 2'h1);
         assign bank_open[b] = open_r;
         assign rec_busy[b]  = (rec_r != 2'h0);
         assign rows[b*11 +: 11] = row_r;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               open_r <= 1'b0;
               row_r  <= 11'h000;
               rec_r  <= 2'h0;
            end else begin
               if (run_edge & cmd_act & (cmd_bank == b)) begin // RULE24
                  open_r <= 1'b1;
                  row_r  <= addr;
               end else if (pre_cls | rd_cls | rec_cls) begin
                  open_r <= 1'b0;
               end
               // recovery counts internal edges, so suspend stretches it
               if (rec_go) begin
                  rec_r <= twr;
               end else if (pre_cls | rec_cls) begin
                  rec_r <= 2'h0;
               end else if (run_edge & rec_busy[b]) begin
                  rec_r <= rec_r - 2'h1;
               end
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_state    <= PS_RUN;
         cke_prev     <= 1'b0;
         burst_active <= 1'b0;
         burst_rd     <= 1'b0;
         burst_ap     <= 1'b0;
         burst_bank   <= 2'h0;
         burst_col    <= 8'h00;
         burst_left   <= 9'h000;
         ref_cnt      <= 2'h0;
      end else begin
         case (pwr_state)
            PS_RUN: begin
               if (run_edge & ~cke) begin
                  // read data still in flight counts as an access
                  if (burst_active | new_acc | mem_rd_en |
                      rd_v0 | rd_v1) begin
                     pwr_state <= PS_SUSP; // RULE9
                  end else if (is_nop(cs_n, code)) begin // RULE4
                     pwr_state <= (bank_open == 4'h0) ? PS_PRE_PD : // RULE5
                                  PS_ACT_PD;
                  end
               end
               cke_prev <= cke;
            end
            PS_SUSP: begin
               // this edge is frozen; cke high lets the next one run
               if (cke) begin
                  pwr_state <= PS_RUN; // RULE12
               end
               cke_prev <= cke;
            end
            PS_PRE_PD, PS_ACT_PD: begin
               // only cke and a nop or deselect command are looked at while powered down
               if (cke & is_nop(cs_n, code)) begin // RULE8 RULE6
                  pwr_state <= PS_RUN;
                  cke_prev  <= 1'b1;
               end
            end
            default: begin
               pwr_state <= PS_RUN;
               cke_prev  <= 1'b0;
            end
         endcase
         if (acc_go) begin
            burst_active <= ~acc_last;
            burst_rd     <= acc_rd;
            burst_ap     <= acc_ap;
            burst_bank   <= acc_bank;
            burst_col    <= acc_col + 8'h01;
            burst_left   <= acc_left - 9'h001;
         end else if (run_edge & stop) begin
            burst_active <= 1'b0;
         end
         if (run_edge & cmd_ref & (bank_open == 4'h0) &
             (ref_cnt != `SPPS_INIT_REFS)) begin // RULE22
            ref_cnt <= ref_cnt + 2'h1;
         end
      end
   end

   // memory strobes and read pipeline; held on suspended edges, except mem_wr_en, which clears
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_wr_en <= 1'b0;
         mem_rd_en <= 1'b0;
         mem_bank  <= 2'h0;
         mem_row   <= 11'h000;
         mem_col   <= 8'h00;
         mem_wdata <= 32'h00000000;
         rd_v0     <= 1'b0;
         rd_v1     <= 1'b0;
         rd_d0     <= 32'h00000000;
         rd_d1     <= 32'h00000000;
         dqm_d0    <= 1'b0;
         dqm_d1    <= 1'b0;
         dq_out    <= 32'h00000000;
         dq_oe     <= 1'b0;
      end else if (run_edge) begin
         mem_rd_en <= acc_go & acc_rd;
         // write mask acts on the same edge as the data
         mem_wr_en <= acc_go & ~acc_rd & ~dqm; // RULE23
         if (acc_go) begin
            mem_bank  <= acc_bank;
            mem_row   <= rows[acc_bank*11 +: 11];
            mem_col   <= acc_col;
            mem_wdata <= dq_in;
         end
         // a registered write drops reads still in flight
         rd_v0  <= mem_rd_en & ~(new_acc & cmd_wr); // RULE17
         rd_v1  <= rd_v0 & ~(new_acc & cmd_wr);
         rd_d0  <= mem_rdata;
         rd_d1  <= rd_d0;
         dqm_d0 <= dqm;
         dqm_d1 <= dqm_d0;
         dq_out <= mode[`SPPS_MODE_CL3] ? rd_d1 : rd_d0;
         dq_oe  <= (mode[`SPPS_MODE_CL3] ? rd_v1 : rd_v0) & ~dqm_d1 &
                   ~(new_acc & cmd_wr); // RULE23
      end else begin
         mem_wr_en <= 1'b0; // RULE11
         // suspended edges keep driving; only power-down drops the bus
         if ((pwr_state == PS_PRE_PD) | (pwr_state == PS_ACT_PD)) begin
            dq_oe <= 1'b0; // RULE6
         end
      end
   end

   // apb: zero wait states, read data captured in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode    <= `SPPS_MODE_RST;
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel & ~penable) begin
            pslverr <= (paddr != `SPPS_MODE_ADDR) &
                       (paddr != `SPPS_STATUS_ADDR);
            if (paddr == `SPPS_MODE_ADDR) begin
               prdata <= {27'h0000000, mode};
            end else if (paddr == `SPPS_STATUS_ADDR) begin
               prdata <= {20'h00000, rec_busy,
                          (ref_cnt == `SPPS_INIT_REFS), burst_active,
                          pwr_state, bank_open};
            end else begin
               prdata <= 32'h00000000;
            end
         end
         if (psel & penable & pwrite & (paddr == `SPPS_MODE_ADDR)) begin
            mode <= pwdata[`SPPS_MODE_W-1:0];
         end
      end
   end

endmodule
`default_nettype wire

// ==== sim/spps_chk_sva.sv ====
// port assertions for the sdram command core
`timescale 1ns/100ps
`default_nettype none
`include "spps_defs.vh"
module spps_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [31:0] dq_in,
   input wire logic [31:0] dq_out,
   input wire logic        dq_oe,
   input wire logic        mem_wr_en,
   input wire logic        mem_rd_en,
   input wire logic [31:0] mem_wdata
);
   logic cke_q;
   logic wbm;
   logic wr_hit;
   logic rd_hit;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write on a live edge; a frozen edge never counts
   assign wr_hit = cke_q && !cs_n && ras_n && !cas_n && !we_n;
   assign rd_hit = cke_q && !cs_n && ras_n && !cas_n && we_n;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cke_q <= 1'b0;
         wbm <= 1'b0;
      end else begin
         cke_q <= cke;
         if (psel && penable && pwrite && paddr == `SPPS_MODE_ADDR)
            wbm <= pwdata[`SPPS_MODE_WBM];
      end
   end
   sequence cke_gap;
      !cke ##1 1'b1;
   endsequence
   pready_up_a: assert property ($past(presetn) |-> pready)
      else $error("pready low outside reset");
   apb_err_a: assert property (psel && penable |-> pslverr ==
      (paddr != `SPPS_MODE_ADDR && paddr != `SPPS_STATUS_ADDR))
      else $error("pslverr wrong for address");
   susp_no_wr_a: assert property (cke_gap |=> !mem_wr_en)
      else $error("store on a suspended edge");
   susp_hold_a: assert property (cke_gap |=> $stable(dq_out)
      && $stable(dq_oe) && $stable(mem_rd_en))
      else $error("outputs moved on a suspended edge");
   single_write_a: assert property (wbm && mem_wr_en && !wr_hit
      |=> !mem_wr_en)
      else $error("burst write in single write mode");
   wr_data_a: assert property (mem_wr_en |->
      mem_wdata == $past(dq_in))
      else $error("stored data not from its edge");
   wr_drop_oe_a: assert property (wr_hit |=> !dq_oe)
      else $error("read data driven after write");
   one_strobe_a: assert property (!(mem_wr_en && mem_rd_en))
      else $error("read and write strobes together");
   rd_stop_wr_a: assert property (rd_hit |=> !mem_wr_en)
      else $error("store after an interrupting read");
endmodule
bind spps_core spps_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .cke(cke),
   .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
   .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_wdata(mem_wdata));
`default_nettype wire

// ==== sim/spps_ctrl.sv ====
// controller model: sdram commands out, storage words back
`timescale 1ns/100ps
`default_nettype none
`include "spps_defs.vh"
module spps_ctrl (
   input  wire logic        pclk,
   output logic             cke,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [10:0]      addr,
   output logic             bank_select_low,
   output logic             bank_select_high,
   output logic             dqm,
   output logic [31:0]      dq_in,
   input  wire logic [1:0]  mem_bank,
   input  wire logic [10:0] mem_row,
   input  wire logic [7:0]  mem_col,
   output logic [31:0]      mem_rdata
);
   // storage answers with its own address, so every word is predictable
   assign mem_rdata = {mem_bank, mem_row, 11'h000, mem_col};
   initial begin
      {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3E;
      {bank_select_high, bank_select_low, addr} = 13'h0000;
      dq_in = 32'h0;
   end
   // one call sets what the next edge samples
   task automatic cmd(input logic [2:0] c, input logic [1:0] b,
      input logic [10:0] a, input logic k, input logic m,
      input logic [31:0] d);
      @(posedge pclk);
      {cke, dqm, cs_n} <= {k, m, 1'b0};
      {ras_n, cas_n, we_n} <= c;
      {bank_select_high, bank_select_low} <= b;
      addr <= a;
      dq_in <= d;
   endtask
   // pause then two refreshes before any traffic
   task automatic init();
      repeat (12500) @(posedge pclk);
      repeat (2) begin
         cmd(`SPPS_CMD_REF, 2'h0, 11'h000, 1'b1, 1'b0, 32'h0);
         cmd(`SPPS_CMD_NOP, 2'h0, 11'h000, 1'b1, 1'b0, 32'h0);
      end
   endtask
endmodule
`default_nettype wire

// ==== sim/spps_core_tb_top.sv ====
// self-checking bench for the sdram command core
`timescale 1ns/100ps
`default_nettype none
`include "spps_defs.vh"
module spps_core_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        cke, cs_n, ras_n, cas_n, we_n, bsl, bsh, dqm, dq_oe;
   logic        mem_wr_en, mem_rd_en;
   logic [7:0]  paddr, mem_col;
   logic [10:0] addr, mem_row;
   logic [1:0]  mem_bank;
   logic [31:0] pwdata, prdata, dq_in, dq_out, mem_rdata, mem_wdata;
   logic [31:0] r, last_dq;
   int          bad_count = 0;
   int          num_checks = 0;
   int          wr_cnt = 0;
   int          n;
   spps_core u_spps_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
      .bank_select_low(bsl), .bank_select_high(bsh), .dqm(dqm),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .mem_rdata(mem_rdata),
      .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_bank(mem_bank),
      .mem_row(mem_row), .mem_col(mem_col), .mem_wdata(mem_wdata));
   spps_ctrl u_ctrl (.pclk(pclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bsl),
      .bank_select_high(bsh), .dqm(dqm), .dq_in(dq_in),
      .mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
      .mem_rdata(mem_rdata));
   always @(posedge pclk) begin
      if (mem_wr_en === 1'b1)
         wr_cnt <= wr_cnt + 1;
      if (dq_oe === 1'b1)
         last_dq <= dq_out;
   end
   task automatic chk(input string s, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic st(input logic [31:0] m, exp);
      apb(1'b0, `SPPS_STATUS_ADDR, 32'h0);
      chk("status", r & m, exp);
   endtask
   task automatic sd(input logic [2:0] c, input logic [1:0] b,
      input logic [10:0] a, input logic k, input logic m);
      u_ctrl.cmd(c, b, a, k, m, 32'hC0DE0000 | 32'(wr_cnt));
   endtask
   task automatic regs_test();
      apb(1'b0, `SPPS_MODE_ADDR, 32'h0);
      chk("mode reset", r, 32'h0);
      apb(1'b1, `SPPS_MODE_ADDR, 32'hFFFFFFFF);
      apb(1'b0, `SPPS_MODE_ADDR, 32'h0);
      chk("mode bits", r, 32'h1F);
      apb(1'b1, `SPPS_STATUS_ADDR, 32'hFF);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped", {r[30:0], e}, 32'h1);
   endtask
   task automatic burst_test();
      st(32'hFF, 32'h80);
      apb(1'b1, `SPPS_MODE_ADDR, 32'h02);
      n = wr_cnt;
      sd(`SPPS_CMD_ACT, 2'h0, 11'h123, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h0, 11'h003, 1'b1, 1'b0);
      repeat (4) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      chk("burst words", 32'(wr_cnt - n), 32'h2);
      apb(1'b1, `SPPS_MODE_ADDR, 32'h0A);
      n = wr_cnt;
      sd(`SPPS_CMD_WR, 2'h2, 11'h000, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h0, 11'h005, 1'b1, 1'b0);
      repeat (4) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      chk("single words", 32'(wr_cnt - n), 32'h1);
   endtask
   task automatic pd_test();
      sd(`SPPS_CMD_ACT, 2'h1, 11'h000, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'hF, 32'h3);
      sd(`SPPS_CMD_PRE, 2'h1, 11'h000, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b0, 1'b0);
      st(32'h3F, 32'h21);
      sd(`SPPS_CMD_ACT, 2'h2, 11'h000, 1'b0, 1'b0);
      // leave early, long before any refresh is due
      repeat (2) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'h3F, 32'h01);
      sd(`SPPS_CMD_PRE, 2'h2, 11'h400, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b0, 1'b0);
      st(32'h3F, 32'h10);
      repeat (2) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
   endtask
   task automatic susp_test();
      apb(1'b1, `SPPS_MODE_ADDR, 32'h04);
      n = wr_cnt;
      sd(`SPPS_CMD_ACT, 2'h0, 11'h123, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h0, 11'h000, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b0, 1'b0);
      st(32'h7F, 32'h71);
      repeat (6) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      chk("resumed words", 32'(wr_cnt - n), 32'h4);
   endtask
   task automatic cap_test();
      sd(`SPPS_CMD_ACT, 2'h1, 11'h055, 1'b1, 1'b0);
      sd(`SPPS_CMD_RD, 2'h0, 11'h408, 1'b1, 1'b0);
      // mask two edges ahead; the first read word is still driven up to the write edge
      repeat (2) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b1);
      sd(`SPPS_CMD_WR, 2'h1, 11'h000, 1'b1, 1'b0);
      repeat (6) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      chk("read word", last_dq, {13'h0123, 11'h000, 8'h08});
      st(32'hF, 32'h2);
   endtask
   task automatic ap_test();
      apb(1'b1, `SPPS_MODE_ADDR, 32'h14);
      n = wr_cnt;
      sd(`SPPS_CMD_ACT, 2'h0, 11'h0AA, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h1, 11'h400, 1'b1, 1'b0);
      sd(`SPPS_CMD_RD, 2'h0, 11'h010, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'h20F, 32'h203);
      repeat (6) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'h20F, 32'h001);
      chk("cut words", 32'(wr_cnt - n), 32'h1);
      chk("ap read word", last_dq, {13'h00AA, 11'h000, 8'h13});
      n = wr_cnt;
      sd(`SPPS_CMD_ACT, 2'h1, 11'h055, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h1, 11'h400, 1'b1, 1'b0);
      sd(`SPPS_CMD_WR, 2'h0, 11'h020, 1'b1, 1'b0);
      sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'h20F, 32'h203);
      repeat (6) sd(`SPPS_CMD_NOP, 2'h0, 11'h0, 1'b1, 1'b0);
      st(32'h20F, 32'h001);
      chk("cut write words", 32'(wr_cnt - n), 32'h5);
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      test_done();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      regs_test();
      u_ctrl.init();
      burst_test();
      pd_test();
      susp_test();
      cap_test();
      ap_test();
      test_done();
   end
endmodule
`default_nettype wire
